// ==== rtl/mcs_regs.vh ====
`ifndef MCS_REGS_VH
`define MCS_REGS_VH
// ****************************************
// Register map.
// ****************************************
`define MCS_ADDR_W 8
`define MCS_DATA_W 32
`define MCS_CTRL2_ADDR 8'h01
`define MCS_SYNCADJ_ADDR 8'h1b
`define MCS_CTRL2_RESET 32'h0000_0900
`define MCS_SYNCADJ_RESET 32'h0000_0000
`define MCS_CTRL2_OUTEN_BIT 9
`define MCS_CTRL2_MUXEN_BIT 8
`define MCS_ADJ_SYNCEN_BIT 6
`define MCS_ADJ_OUTDLY_HI 5
`define MCS_ADJ_OUTDLY_LO 3
`define MCS_ADJ_INDLY_HI 2
`define MCS_ADJ_INDLY_LO 0
`define MCS_UNMAPPED_DATA 32'h0000_0000
// ****************************************
// Timing.
// ****************************************
`define MCS_DLY_W 3
`define MCS_GEN_DIV 384
`define MCS_GEN_HIGH 256
`define MCS_DIV_W 9
`define MCS_CAL_SYNC_PERIODS 16
`define MCS_CAL_CNT_W 5
`endif

// ==== rtl/mcs_delay_line.v ====
`timescale 1ns/1ns
`include "mcs_regs.vh"
// ****************************************
// Programmable delay of 0 to 7 clock steps.
// ****************************************
module mcs_delay_line #(
  parameter DLY_W = `MCS_DLY_W
) (
  clock,
  rst_b,
  dataIn,
  delaySel,
  dataOut
);
  input wire clock;
  input wire rst_b;
  input wire dataIn;
  input wire [DLY_W-1:0] delaySel;
  output wire dataOut;

  localparam TAPS = 1 << DLY_W;
  reg [TAPS-1:0] tap_reg;
  wire [TAPS-1:0] tap_next;

  // Tap 0 is the undelayed input; each further tap adds one step.
  assign tap_next = {tap_reg[TAPS-2:0], dataIn};

  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      tap_reg <= {TAPS{1'b0}};
    else
      tap_reg <= tap_next;
  end

  assign dataOut = tap_next[delaySel];
endmodule // mcs_delay_line

// ==== rtl/mcs_sync_receiver.v ====
`timescale 1ns/1ns
`include "mcs_regs.vh"
// Operation
// - Generator output is delayed by the output adjust field, bits 5 to 3; pass-through sync output is not.
// - Sync input is delayed by the input adjust field, bits 2 to 0, before detection.
// - Without generator enabled, sync input is buffered onto sync output.
// - Edge detector gives a one-cycle pulse per sync input period.
// - Sync input rising edge is found by sampling on core clock edges.
// - Clock generator counter steps each cycle and loads preset on pulse.
// - Preset state lasts one cycle, then normal stepping resumes.
// - Each adjust field takes 0 to 7, each count adding one step.
// - Generator drives sync output only with both enable bits set.
// - Generator output runs at clock over 384 with 67 percent duty.
// - With sync enabled, calibration waits 16 sync periods after first step.
module mcs_sync_receiver #(
  parameter GEN_W = 8,
  parameter [GEN_W-1:0] GEN_PRESET = 8'h00,
  parameter CAL_REST_CYCLES = 16
) (
  clock,
  rst_b,
  regWrEn,
  regAddr,
  regWrData,
  regRdData,
  syncIn,
  syncOut,
  syncOutOe,
  syncPulse,
  clockGenState,
  calStart,
  calBusy,
  calDone
);
  input wire clock;
  input wire rst_b;
  input wire regWrEn;
  input wire [`MCS_ADDR_W-1:0] regAddr;
  input wire [`MCS_DATA_W-1:0] regWrData;
  output reg [`MCS_DATA_W-1:0] regRdData;
  input wire syncIn;
  output reg syncOut;
  output reg syncOutOe;
  output reg syncPulse;
  output reg [GEN_W-1:0] clockGenState;
  input wire calStart;
  output reg calBusy;
  output reg calDone;

  // ****************************************
  // Registers.
  // ****************************************
  reg [`MCS_DATA_W-1:0] ctrlTwo_reg;
  reg [`MCS_DATA_W-1:0] syncAdj_reg;
  reg [`MCS_DATA_W-1:0] rdData_next;

  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrlTwo_reg <= `MCS_CTRL2_RESET;
      syncAdj_reg <= `MCS_SYNCADJ_RESET;
    end
    else if (regWrEn)
    begin
      if (regAddr == `MCS_CTRL2_ADDR)
        ctrlTwo_reg <= regWrData;
      if (regAddr == `MCS_SYNCADJ_ADDR)
        syncAdj_reg <= regWrData;
    end
  end

  always @*
  begin
    case (regAddr)
      `MCS_CTRL2_ADDR: rdData_next = ctrlTwo_reg;
      `MCS_SYNCADJ_ADDR: rdData_next = syncAdj_reg;
      default: rdData_next = `MCS_UNMAPPED_DATA;
    endcase
  end

  wire genEnable = ctrlTwo_reg[`MCS_CTRL2_OUTEN_BIT];
  wire muxEnable = ctrlTwo_reg[`MCS_CTRL2_MUXEN_BIT];
  wire syncEnable = syncAdj_reg[`MCS_ADJ_SYNCEN_BIT];
  wire [`MCS_DLY_W-1:0] outDelay = syncAdj_reg[`MCS_ADJ_OUTDLY_HI:`MCS_ADJ_OUTDLY_LO];
  wire [`MCS_DLY_W-1:0] inDelay = syncAdj_reg[`MCS_ADJ_INDLY_HI:`MCS_ADJ_INDLY_LO];

  // ****************************************
  // Sync receiver.
  // ****************************************
  reg syncMeta_reg;
  reg syncSafe_reg;
  reg syncPrev_reg;
  wire syncDelayed;

  // The first stage may go metastable, so only the second stage reads it.
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      syncMeta_reg <= 1'b0;
      syncSafe_reg <= 1'b0;
    end
    else
    begin
      syncMeta_reg <= syncIn;
      syncSafe_reg <= syncMeta_reg;
    end
  end

  mcs_delay_line #(
    .DLY_W(`MCS_DLY_W)
  ) inDelayLine (
    .clock(clock),
    .rst_b(rst_b),
    .dataIn(syncSafe_reg),
    .delaySel(inDelay),
    .dataOut(syncDelayed)
  );

  wire syncEdge = syncDelayed & ~syncPrev_reg;

  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      syncPrev_reg <= 1'b0;
      syncPulse <= 1'b0;
    end
    else
    begin
      syncPrev_reg <= syncDelayed;
      syncPulse <= syncEdge;
    end
  end

  // ****************************************
  // Internal clock generator.
  // ****************************************
  reg [GEN_W-1:0] clockGen_next;

  always @*
  begin
    if (syncPulse)
      clockGen_next = GEN_PRESET;
    else
      clockGen_next = clockGenState + {{(GEN_W-1){1'b0}}, 1'b1};
  end

  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      clockGenState <= {GEN_W{1'b0}};
    else
      clockGenState <= clockGen_next;
  end

  // ****************************************
  // Sync output generator and mux.
  // ****************************************
  reg [`MCS_DIV_W-1:0] div_reg;
  reg genClk_reg;
  wire genDelayed;
  wire passDelayed;
  reg syncOut_next;
  reg syncOutOe_next;

  // Free-running: the detected pulse never touches this divider.
  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      div_reg <= {`MCS_DIV_W{1'b0}};
      genClk_reg <= 1'b0;
    end
    else
    begin
      if (div_reg == `MCS_GEN_DIV - 1)
        div_reg <= {`MCS_DIV_W{1'b0}};
      else
        div_reg <= div_reg + {{(`MCS_DIV_W-1){1'b0}}, 1'b1};
      genClk_reg <= (div_reg < `MCS_GEN_HIGH);
    end
  end

  // 256 of 384 cycles high gives exactly two-thirds duty, which rounds to 67 percent.
  mcs_delay_line #(
    .DLY_W(`MCS_DLY_W)
  ) outDelayLine (
    .clock(clock),
    .rst_b(rst_b),
    .dataIn(genClk_reg),
    .delaySel(outDelay),
    .dataOut(genDelayed)
  );

  assign passDelayed = syncSafe_reg;

  always @*
  begin
    if (genEnable)
    begin
      syncOut_next = genDelayed & muxEnable;
      syncOutOe_next = muxEnable;
    end
    else
    begin
      syncOut_next = passDelayed;
      syncOutOe_next = 1'b1;
    end
  end

  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      syncOut <= 1'b0;
      syncOutOe <= 1'b0;
      regRdData <= `MCS_UNMAPPED_DATA;
    end
    else
    begin
      syncOut <= syncOut_next;
      syncOutOe <= syncOutOe_next;
      regRdData <= rdData_next;
    end
  end

  // ****************************************
  // Calibration sequencing.
  // ****************************************
  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_FIRST = 4'h2;
  localparam [3:0] ST_WAIT = 4'h4;
  localparam [3:0] ST_REST = 4'h8;
  reg [3:0] state_reg;
  reg [3:0] state_next;
  reg [`MCS_CAL_CNT_W-1:0] calCnt_reg;
  reg [`MCS_CAL_CNT_W-1:0] calCnt_next;
  reg [15:0] restCnt_reg;
  reg [15:0] restCnt_next;

  // Without a sync input and with sync enabled, calibration stalls here for good.
  always @*
  begin
    state_next = state_reg;
    calCnt_next = calCnt_reg;
    restCnt_next = restCnt_reg;
    case (state_reg)
      ST_IDLE:
        if (calStart)
          state_next = ST_FIRST;
      ST_FIRST:
      begin
        calCnt_next = {`MCS_CAL_CNT_W{1'b0}};
        restCnt_next = 16'h0000;
        state_next = syncEnable ? ST_WAIT : ST_REST;
      end
      ST_WAIT:
        if (syncPulse)
        begin
          if (calCnt_reg == `MCS_CAL_SYNC_PERIODS - 1)
            state_next = ST_REST;
          calCnt_next = calCnt_reg + {{(`MCS_CAL_CNT_W-1){1'b0}}, 1'b1};
        end
      ST_REST:
      begin
        restCnt_next = restCnt_reg + 16'h0001;
        if (restCnt_reg == CAL_REST_CYCLES - 1)
          state_next = ST_IDLE;
      end
      default: state_next = ST_IDLE;
    endcase
  end

  always @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_reg <= ST_IDLE;
      calCnt_reg <= {`MCS_CAL_CNT_W{1'b0}};
      restCnt_reg <= 16'h0000;
      calBusy <= 1'b0;
      calDone <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      calCnt_reg <= calCnt_next;
      restCnt_reg <= restCnt_next;
      calBusy <= (state_next != ST_IDLE);
      calDone <= (state_reg == ST_REST) && (state_next == ST_IDLE);
    end
  end
endmodule // mcs_sync_receiver

// ==== verif/mcs_sync_monitor.sv ====
`timescale 1ns/1ns
module mcs_sync_monitor #(
  parameter GEN_W = 8,
  parameter [GEN_W-1:0] GEN_PRESET = 8'h00
) (
  input wire clock,
  input wire rst_b,
  input wire regWrEn,
  input wire [7:0] regAddr,
  input wire [31:0] regWrData,
  input wire syncIn,
  input wire syncOut,
  input wire syncOutOe,
  input wire syncPulse,
  input wire [GEN_W-1:0] clockGenState,
  input wire calBusy,
  input wire calDone
);
  // ****
  // Shadow of the output mode bits.
  // ****
  reg [1:0] modeReg;
  reg [8:0] hiCnt;
  reg [9:0] quiet;
  always @(posedge clock or negedge rst_b)
    if (!rst_b)
    begin
      modeReg <= 2'h1;
      hiCnt <= 9'h000;
      quiet <= 10'h000;
    end
    else
    begin
      if (regWrEn && regAddr == 8'h01)
        modeReg <= regWrData[9:8];
      hiCnt <= syncOut ? hiCnt + 9'h001 : 9'h000;
      // Any write may shift the phase, so duty is judged only after a quiet spell.
      quiet <= regWrEn ? 10'h000 : quiet + {9'h000, ~&quiet};
    end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  chk_pulse_single: assert property (syncPulse |=> !syncPulse)
    else $error("sync pulse too long");
  chk_preset_load: assert property (syncPulse |=> clockGenState == GEN_PRESET)
    else $error("no preset after pulse");
  chk_gen_step: assert property (!syncPulse |=> clockGenState == $past(clockGenState) + 1'b1)
    else $error("generator did not step");
  chk_out_off: assert property (modeReg == 2'h2 |=> !syncOutOe && !syncOut)
    else $error("output driven with mux off");
  chk_out_pass: assert property (!modeReg[1] |=> syncOutOe)
    else $error("pass mode not driving");
  chk_pass_data: assert property (!modeReg[1] [*4] |-> syncOut == $past(syncIn, 3))
    else $error("pass data wrong");
  chk_gen_duty: assert property (quiet > 10'h300 && modeReg == 2'h3 && $fell(syncOut) |-> hiCnt == 9'h100)
    else $error("generator duty wrong");
  chk_cal_done: assert property (calDone |-> $past(calBusy) && !calBusy)
    else $error("done without busy");
  cov_pulse: cover property (syncPulse);
  cov_gen: cover property (modeReg == 2'h3 && $fell(syncOut));
  cov_cal: cover property (calDone);
endmodule // mcs_sync_monitor
bind mcs_sync_receiver mcs_sync_monitor #(.GEN_W(GEN_W), .GEN_PRESET(GEN_PRESET)) mcs_sync_monitor_inst (
  .clock(clock), .rst_b(rst_b), .regWrEn(regWrEn), .regAddr(regAddr), .regWrData(regWrData),
  .syncIn(syncIn), .syncOut(syncOut), .syncOutOe(syncOutOe), .syncPulse(syncPulse),
  .clockGenState(clockGenState), .calBusy(calBusy), .calDone(calDone));

// ==== verif/mcs_sync_source.sv ====
`timescale 1ns/1ns
module mcs_sync_source (
  input wire run,
  input wire loopBack,
  input wire syncOutPin,
  output wire syncIn
);
  reg linkClk = 1'b0;
  // ****
  // Link clock, standing low between frames.
  // ****
  initial
  begin
    #3;
    forever
    begin
      #40;
      linkClk = run ? ~linkClk : 1'b0;
    end
  end
  assign syncIn = loopBack ? syncOutPin : linkClk;
endmodule // mcs_sync_source

// ==== verif/mcs_sync_receiver_tb_top.sv ====
`timescale 1ns/1ns
module mcs_sync_receiver_tb_top;
  // One shared core clock stands for the edge-aligned reference.
  reg clock = 1'b0;
  reg rst_b = 1'b0;
  reg regWrEn = 1'b0;
  reg [7:0] regAddr = 8'h00;
  reg [31:0] regWrData = 32'h0;
  reg calStart = 1'b0;
  reg run = 1'b0;
  reg loopBack = 1'b0;
  wire [31:0] regRdData;
  wire [7:0] clockGenState;
  wire syncIn, syncOut, syncOutOe, syncPulse, calBusy, calDone;
  integer bad_count = 0;
  integer checked = 0;
  integer n, c, t, t0;
  initial
    forever #4 clock = ~clock;
  mcs_sync_receiver #(.CAL_REST_CYCLES(2)) mcs_sync_receiver_inst (.clock(clock), .rst_b(rst_b),
    .regWrEn(regWrEn), .regAddr(regAddr), .regWrData(regWrData), .regRdData(regRdData),
    .syncIn(syncIn), .syncOut(syncOut), .syncOutOe(syncOutOe), .syncPulse(syncPulse),
    .clockGenState(clockGenState), .calStart(calStart), .calBusy(calBusy), .calDone(calDone));
  mcs_sync_source mcs_sync_source_inst (.run(run), .loopBack(loopBack), .syncOutPin(syncOut),
    .syncIn(syncIn));
  // ****
  // Access and check tasks.
  // ****
  task end_of_test;
  begin
    $display("checked %0d bad %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  end
  endtask
  task chk(input [31:0] seen, input [31:0] exp);
  begin
    checked = checked + 1;
    if (seen !== exp)
    begin
      bad_count = bad_count + 1;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  end
  endtask
  task step;
  begin
    @(posedge clock);
    #1;
  end
  endtask
  task tmo(input integer k);
    if (n >= k)
    begin
      chk(0, 1);
      end_of_test;
    end
  endtask
  task wr(input [7:0] a, input [31:0] d);
  begin
    @(posedge clock);
    regAddr <= a;
    regWrData <= d;
    regWrEn <= 1'b1;
    @(posedge clock);
    regWrEn <= 1'b0;
  end
  endtask
  task rd(input [7:0] a, input [31:0] exp);
  begin
    @(posedge clock);
    regAddr <= a;
    @(posedge clock);
    step;
    chk(regRdData, exp);
  end
  endtask
  task lat(input [31:0] d);
  begin
    wr(8'h1b, d);
    step;
    for (n = 0; n < 20 && syncIn !== 1'b0; n = n + 1) step;
    tmo(20);
    for (n = 0; n < 20 && syncIn !== 1'b1; n = n + 1) step;
    tmo(20);
    for (n = 0; n < 20 && syncPulse !== 1'b1; n = n + 1) step;
    chk(n, d + 2);
  end
  endtask
  task cnt(input integer k);
  begin
    c = 0;
    repeat (k)
    begin
      step;
      c = c + syncPulse;
    end
  end
  endtask
  task rise;
  begin
    for (n = 0; n < 800 && syncOut !== 1'b0; n = n + 1) step;
    tmo(800);
    for (n = 0; n < 800 && syncOut !== 1'b1; n = n + 1) step;
    tmo(800);
    t = $time;
  end
  endtask
  task wt(input integer k);
  begin
    #1;
    for (n = 0; n < k && calDone !== 1'b1; n = n + 1) step;
  end
  endtask
  task cal(input integer k);
  begin
    @(posedge clock);
    calStart <= 1'b1;
    @(posedge clock);
    calStart <= 1'b0;
    wt(k);
  end
  endtask
  // ****
  // Test sequence.
  // ****
  initial
  begin
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    rd(8'h01, 32'h900);
    rd(8'h1b, 32'h0);
    wr(8'h1b, 32'h3f);
    wr(8'h55, 32'hff);
    wr(8'h01, 32'h0);
    rd(8'h1b, 32'h3f);
    rd(8'h01, 32'h0);
    rd(8'h55, 32'h0);
    chk(syncOutOe, 1);
    $display("test registers done");
    run <= 1'b1;
    lat(0);
    lat(7);
    cnt(200);
    chk(c, 20);
    $display("test sync input done");
    wr(8'h1b, 32'h0);
    wr(8'h01, 32'h200);
    repeat (3) step;
    chk(syncOutOe, 0);
    wr(8'h01, 32'h300);
    rise;
    t0 = t;
    rise;
    chk(t - t0, 3072);
    wr(8'h1b, 32'h38);
    repeat (1000) step;
    rise;
    chk((t - t0) % 3072, 56);
    chk(syncOutOe, 1);
    $display("test generator done");
    run <= 1'b0;
    loopBack <= 1'b1;
    cnt(20);
    cnt(1152);
    chk(c, 3);
    $display("test loop back done");
    loopBack <= 1'b0;
    cal(10);
    chk(calDone, 1);
    wr(8'h1b, 32'h40);
    cal(300);
    chk(calBusy, 1);
    run <= 1'b1;
    wt(400);
    tmo(400);
    chk(calDone, 1);
    $display("test calibration done");
    end_of_test;
  end
endmodule // mcs_sync_receiver_tb_top
